// ---- src/ledpp_params.svh ----
`ifndef LEDPP_PARAMS_SVH
`define LEDPP_PARAMS_SVH
`define LEDPP_STAGES       7
`define LEDPP_MIRROR_K     746
`define LEDPP_CUR_W        16
`define LEDPP_TGT_W        32
`define LEDPP_CLK_HZ       10000000
`define LEDPP_SETTLE_US    100
`define LEDPP_SETTLE_CYC   ((`LEDPP_SETTLE_US * (`LEDPP_CLK_HZ / 1000000)))
`endif

// ---- src/ledpp_pkg.sv ----
`default_nettype none
package ledpp_pkg;
   typedef enum logic [1:0] {
      LEDPP_OFF      = 2'b00,
      LEDPP_SETTLING = 2'b01,
      LEDPP_ON       = 2'b10
   } ledpp_boost_t;
endpackage : ledpp_pkg
`default_nettype wire

// ---- src/ledpp_target.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ledpp_params.svh"
module ledpp_target (
   input  wire logic                      core_clk_in,
   input  wire logic                      reset_in,
   input  wire logic                      local_mode_n_in,
   input  wire logic [2:0]                level_code_in,
   input  wire logic [`LEDPP_CUR_W-1:0]   reference_current_pin_in,
   input  wire logic [`LEDPP_CUR_W-1:0]   photo_current_in,
   output logic      [`LEDPP_TGT_W-1:0]   peak_target_x2_out,
   output logic      [`LEDPP_TGT_W-1:0]   valley_target_x2_out
);
   typedef struct packed {
      logic [`LEDPP_TGT_W-1:0] peak;
      logic [`LEDPP_TGT_W-1:0] valley;
   } ledpp_tgt_state_t;
   ledpp_tgt_state_t st_r;
   ledpp_tgt_state_t st_nxt;
   logic [`LEDPP_TGT_W-1:0] diff;
   logic [`LEDPP_TGT_W-1:0] base;
   logic [`LEDPP_TGT_W-1:0] mult;
   localparam logic [`LEDPP_TGT_W-1:0] K = `LEDPP_TGT_W'(`LEDPP_MIRROR_K);
   // targets kept doubled so the half step stays exact in integers
   always_comb
   begin
      st_nxt = st_r;
      diff = '0;
      mult = '0;
      if (reference_current_pin_in > photo_current_in)
      begin
         diff = `LEDPP_TGT_W'(reference_current_pin_in - photo_current_in);
      end
      base = `LEDPP_TGT_W'(diff * K);
      mult = `LEDPP_TGT_W'({level_code_in, 1'b1});
      if (!local_mode_n_in)
      begin
         // local mode: reference pin only, clock-programmed code unused
         st_nxt.peak   = `LEDPP_TGT_W'(reference_current_pin_in * K * 2);
         st_nxt.valley = st_nxt.peak;
      end
      else
      begin
         st_nxt.peak   = `LEDPP_TGT_W'(base * mult);
         st_nxt.valley = base;
      end
      if (reset_in)
      begin
         st_nxt = '0;
      end
   end
   always_ff @(posedge core_clk_in)
   begin
      st_r <= st_nxt;
   end
   assign peak_target_x2_out   = st_r.peak;
   assign valley_target_x2_out = st_r.valley;
endmodule : ledpp_target
`default_nettype wire

// ---- src/ledpp_programmer.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "ledpp_params.svh"
module ledpp_programmer (
   input  wire logic                      core_clk_in,
   input  wire logic                      reset_in,
   input  wire logic                      cs_n_in,
   input  wire logic                      pulse_clk_in,
   input  wire logic                      local_mode_n_in,
   input  wire logic [`LEDPP_CUR_W-1:0]   reference_current_pin_in,
   input  wire logic [`LEDPP_CUR_W-1:0]   photo_current_in,
   output logic      [2:0]                level_code_out,
   output logic                           shutdown_out,
   output logic                           boost_enable_out,
   output logic                           current_settled_out,
   output logic      [`LEDPP_TGT_W-1:0]   peak_target_x2_out,
   output logic      [`LEDPP_TGT_W-1:0]   valley_target_x2_out
);
   localparam int STAGES = `LEDPP_STAGES;
   localparam logic [15:0] SETTLE = 16'(`LEDPP_SETTLE_CYC - 1);
   typedef struct packed {
      logic                      cs_d;
      logic                      clk_d;
      logic                      token;
      logic [STAGES-1:0]         level_shift_stages;
      logic [2:0]                level_code;
      ledpp_pkg::ledpp_boost_t   boost;
      logic [15:0]               settle_cnt;
   } ledpp_state_t;
   ledpp_state_t st_r;
   ledpp_state_t st_nxt;
   logic              cs_fall;
   logic              cs_rise;
   logic              clk_rise;
   logic [2:0]        enc;
   logic [2:0]        code_eff;
   logic [STAGES-1:0] shifted;
   // one-hot stages to code; stage n means n pulses
   always_comb
   begin
      enc = 3'h0;
      for (int i = 0; i < STAGES; i++)
      begin
         if (st_r.level_shift_stages[i])
         begin
            enc = 3'(i + 1);
         end
      end
   end
   // token enters stage 1, top stage falls off the end
   genvar g;
   generate
      for (g = 0; g < STAGES; g++)
      begin : g_shift
         if (g == 0)
         begin : g_first
            assign shifted[g] = st_r.token;
         end
         else
         begin : g_rest
            assign shifted[g] = st_r.level_shift_stages[g-1];
         end
      end
   endgenerate
   always_comb
   begin
      st_nxt   = st_r;
      cs_fall  = st_r.cs_d && !cs_n_in;
      cs_rise  = !st_r.cs_d && cs_n_in;
      clk_rise = !st_r.clk_d && pulse_clk_in;
      st_nxt.cs_d  = cs_n_in;
      st_nxt.clk_d = pulse_clk_in;
      if (cs_fall)
      begin
         st_nxt.token = 1'b1;
      end
      else if (cs_rise)
      begin
         // latch the pre-edge contents, then wipe the stages
         st_nxt.level_code         = enc;
         st_nxt.level_shift_stages = '0;
         st_nxt.token              = 1'b0;
      end
      else if (!cs_n_in && !st_r.cs_d && clk_rise)
      begin
         st_nxt.level_shift_stages = shifted;
         if (shifted[0])
         begin
            st_nxt.token = 1'b0;
         end
      end
      // with select held high nothing above fires after its rising edge, so the code holds
      case (st_r.boost)
         ledpp_pkg::LEDPP_OFF:
         begin
            if (st_nxt.level_code != 3'h0)
            begin
               st_nxt.boost      = ledpp_pkg::LEDPP_SETTLING;
               st_nxt.settle_cnt = '0;
            end
         end
         ledpp_pkg::LEDPP_SETTLING:
         begin
            if (st_nxt.level_code == 3'h0)
            begin
               st_nxt.boost = ledpp_pkg::LEDPP_OFF;
            end
            else if (st_r.settle_cnt == SETTLE)
            begin
               st_nxt.boost = ledpp_pkg::LEDPP_ON;
            end
            else
            begin
               st_nxt.settle_cnt = st_r.settle_cnt + 16'h0001;
            end
         end
         ledpp_pkg::LEDPP_ON:
         begin
            if (st_nxt.level_code == 3'h0)
            begin
               st_nxt.boost = ledpp_pkg::LEDPP_OFF;
            end
         end
         default:
         begin
            st_nxt.boost = ledpp_pkg::LEDPP_OFF;
         end
      endcase
      if (reset_in)
      begin
         // stands in for the internal power-on reset
         st_nxt       = '0;
         st_nxt.cs_d  = 1'b1;
         st_nxt.clk_d = 1'b1;
         st_nxt.boost = ledpp_pkg::LEDPP_OFF;
      end
   end
   always_ff @(posedge core_clk_in)
   begin
      st_r <= st_nxt;
   end
   // local mode needs no programmed code; boost runs off the reference alone
   assign code_eff            = st_r.level_code;
   assign level_code_out      = st_r.level_code;
   assign shutdown_out        = local_mode_n_in && (st_r.boost == ledpp_pkg::LEDPP_OFF);
   assign boost_enable_out    = !local_mode_n_in || (st_r.boost != ledpp_pkg::LEDPP_OFF);
   assign current_settled_out = local_mode_n_in && (st_r.boost == ledpp_pkg::LEDPP_ON);
   ledpp_target u_target (
      .core_clk_in              (core_clk_in),
      .reset_in                 (reset_in),
      .local_mode_n_in          (local_mode_n_in),
      .level_code_in            (code_eff),
      .reference_current_pin_in (reference_current_pin_in),
      .photo_current_in         (photo_current_in),
      .peak_target_x2_out       (peak_target_x2_out),
      .valley_target_x2_out     (valley_target_x2_out)
   );
endmodule : ledpp_programmer
`default_nettype wire

// ---- sim/ledpp_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ledpp_checker (
   input wire logic        core_clk_in,
   input wire logic        reset_in,
   input wire logic        cs_n_in,
   input wire logic        local_mode_n_in,
   input wire logic [15:0] reference_current_pin_in,
   input wire logic [15:0] photo_current_in,
   input wire logic [2:0]  level_code_out,
   input wire logic        shutdown_out,
   input wire logic        boost_enable_out,
   input wire logic        current_settled_out,
   input wire logic [31:0] peak_target_x2_out
);
   wire        rm = local_mode_n_in;
   wire [31:0] d;
   // photo above reference gives no current
   assign d = (reference_current_pin_in > photo_current_in) ?
      32'(reference_current_pin_in - photo_current_in) : 32'h0;
   logic [10:0] on_cnt;
   // cycles with a nonzero level; a return to zero restarts settling
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in || level_code_out == 3'h0)
      begin
         on_cnt <= 11'h000;
      end
      else if (on_cnt != 11'h7ff)
      begin
         on_cnt <= on_cnt + 11'h001;
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   a_level_latch: assert property ($changed(level_code_out) |->
      $past(cs_n_in) && !($past(cs_n_in, 2) && $past(cs_n_in, 3))) else $error("latch");
   a_shut_remote: assert property (rm |-> shutdown_out == (level_code_out == 3'h0))
      else $error("shutdown");
   a_boost_level: assert property (rm |-> boost_enable_out == (level_code_out != 3'h0))
      else $error("boost");
   a_local_on: assert property (!rm |-> boost_enable_out && !shutdown_out)
      else $error("local");
   a_settle_mode: assert property (current_settled_out |-> rm && boost_enable_out)
      else $error("settled");
   a_settle_wait: assert property ($rose(boost_enable_out) |=> !current_settled_out [*8])
      else $error("settle early");
   a_settle_time: assert property (rm && level_code_out != 3'h0 |->
      current_settled_out == (on_cnt >= 11'h3e8)) else $error("settle time");
   a_peak_calc: assert property (!$past(reset_in) && $past(rm) |->
      peak_target_x2_out == $past(d) * 32'h2ea * (32'($past(level_code_out)) * 32'h2 + 32'h1))
      else $error("peak");
   a_local_tgt: assert property (!$past(reset_in) && !$past(rm) |->
      peak_target_x2_out == 32'($past(reference_current_pin_in)) * 32'h5d4) else $error("tgt");
   cover property ($rose(current_settled_out));
   cover property (level_code_out == 3'h7);
   cover property (!rm && boost_enable_out);
endmodule : ledpp_checker
bind ledpp_programmer ledpp_checker i_ledpp_checker (.*);
`default_nettype wire

// ---- sim/ledpp_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module ledpp_host (
   input  wire logic       clk_in,
   input  wire logic       start_in,
   input  wire logic [3:0] pulses_in,
   output var logic        cs_n_out,
   output var logic        clk_out,
   output var logic        done_out
);
   task tick;
      @(posedge clk_in) #1 clk_out = 1'b0;
      @(posedge clk_in) #1 clk_out = 1'b1;
   endtask : tick
   initial
   begin
      {cs_n_out, clk_out, done_out} = 3'b110;
      forever
      begin
         @(posedge clk_in iff start_in === 1'b1);
         #1 cs_n_out = 1'b0;
         repeat (pulses_in) tick();
         @(posedge clk_in) #1 cs_n_out = 1'b1;
         // stray pulses with select high must not disturb the level
         repeat (2) tick();
         done_out = 1'b1;
         @(posedge clk_in) #1 done_out = 1'b0;
      end
   end
endmodule : ledpp_host
`default_nettype wire

// ---- sim/led_current_level_pulse_programmer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
   $display("[FAIL] %0t %0h %0h", $time, a, b); end end
module led_current_level_pulse_programmer_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        lm_n = 1'b1;
   logic        go = 1'b0;
   logic [3:0]  np = 4'h0;
   logic [15:0] rf = 16'h0;
   logic [15:0] ph = 16'h0;
   logic        cs_n, pc, done, sd, be, st;
   logic [2:0]  lv;
   logic [31:0] pk, vl, d;
   logic [2:0]  q[$];
   int          failures = 0;
   int          tests_run = 0;
   always #50 clk = ~clk;
   ledpp_host i_ledpp_host (.clk_in(clk), .start_in(go), .pulses_in(np), .cs_n_out(cs_n),
      .clk_out(pc), .done_out(done));
   ledpp_programmer i_ledpp_programmer (.core_clk_in(clk), .reset_in(rst), .cs_n_in(cs_n),
      .pulse_clk_in(pc), .local_mode_n_in(lm_n), .reference_current_pin_in(rf),
      .photo_current_in(ph), .level_code_out(lv), .shutdown_out(sd), .boost_enable_out(be),
      .current_settled_out(st), .peak_target_x2_out(pk), .valley_target_x2_out(vl));
   task results;
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   task run(input logic [3:0] n);
      np = n;
      q.push_back((n > 4'h7) ? 3'h0 : n[2:0]);
      go = 1'b1;
      @(posedge clk) #1 go = 1'b0;
      @(posedge clk iff done === 1'b1) #1;
   endtask : run
   always @(posedge cs_n)
   begin : mon
      logic [2:0] c;
      if (rst === 1'b0)
      begin
         repeat (2) @(posedge clk);
         #1 c = q.pop_front();
         `CHK(lv, c)
         `CHK(sd, lm_n && c == 3'h0)
         `CHK(be, !lm_n || c != 3'h0)
         d = lm_n ? ((rf > ph) ? 32'(rf - ph) : 32'h0) * 32'h2ea : 32'(rf) * 32'h5d4;
         @(posedge clk) #1;
         `CHK(pk, lm_n ? d * (32'(c) * 32'h2 + 32'h1) : d)
         `CHK(vl, d)
      end
   end
   initial
   begin
      void'($urandom(86));
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      `CHK(sd, 1'b1)
      for (int n = 0; n < 10; n++)
      begin
         rf = 16'($urandom);
         ph = (n == 5) ? 16'hffff : 16'($urandom_range(0, rf));
         run(4'(n));
      end
      run(4'h3);
      repeat (990) @(posedge clk);
      #1 `CHK(st, 1'b0)
      repeat (10) @(posedge clk);
      #1 `CHK(st, 1'b1)
      run(4'h0);
      `CHK(st, 1'b0)
      // local mode: select still pulsed and level latched, but targets ignore it
      lm_n = 1'b0;
      run(4'h2);
      run(4'h0);
      results();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      results();
   end
endmodule : led_current_level_pulse_programmer_tb
`default_nettype wire
